/* File: common/commutation_cfg_pkg.sv */
// Register map, reset values and decoding constants for the commutation
// and feedback configuration block.
// Assumes a 16-bit register port with a 5-bit word address.
package commutation_cfg_pkg;

  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 16;
  localparam int ANGLE_W = 10;
  localparam int HALL_N  = 6;
  localparam int SYNC_W  = 5;

  //////////////////////////////////////////////////////////////////////////////
  // Register addresses.
  localparam logic [4:0] ADDR_POLE_PITCH    = 5'h00;
  localparam logic [4:0] ADDR_SCALE_RES     = 5'h01;
  localparam logic [4:0] ADDR_LIMIT_OPT     = 5'h02;
  localparam logic [4:0] ADDR_PHASE_ORDER   = 5'h03;
  localparam logic [4:0] ADDR_INDEX_OFFSET  = 5'h04;
  localparam logic [4:0] ADDR_QUAD_DIR      = 5'h05;
  localparam logic [4:0] ADDR_HALL_BASE     = 5'h06;
  localparam logic [4:0] ADDR_INDEX_WINDOW  = 5'h0c;
  localparam logic [4:0] ADDR_UNLOCK        = 5'h10;
  localparam logic [4:0] ADDR_STATUS        = 5'h11;
  localparam logic [4:0] ADDR_ACTIVE_PITCH  = 5'h12;
  localparam logic [4:0] ADDR_ACTIVE_RES    = 5'h13;
  localparam logic [4:0] ADDR_ACTIVE_LIMIT  = 5'h14;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [15:0] RST_POLE_PITCH   = 16'h0000;
  localparam logic [15:0] RST_SCALE_RES    = 16'h0000;
  localparam logic [15:0] RST_LIMIT_OPT    = 16'h0000;
  localparam logic        RST_PHASE_ORDER  = 1'b1;
  localparam logic [14:0] RST_INDEX_OFFSET = 15'h0000;
  localparam logic        RST_QUAD_DIR     = 1'b0;
  localparam logic [7:0]  RST_INDEX_WINDOW = 8'h16;
  // Entry 0 belongs to Hall code 1, entry 5 to Hall code 6.
  localparam logic [5:0][9:0] RST_HALL_ANGLE =
    {10'h3a7, 10'h253, 10'h2fd, 10'h0ff, 10'h055, 10'h1a9};

  // Value that opens the write protection; the value is arbitrary.
  localparam logic [15:0] UNLOCK_KEY = 16'h5a5a;

  //////////////////////////////////////////////////////////////////////////////
  // Status register fields.
  localparam int STAT_UNLOCKED = 0;
  localparam int STAT_RUNNING  = 1;
  localparam int STAT_REJECTED = 2;

  //////////////////////////////////////////////////////////////////////////////
  // Decimal digit weights of the limit option word and the limit step.
  localparam logic [15:0] DEC_10000 = 16'h2710;
  localparam logic [15:0] DEC_1000  = 16'h03e8;
  localparam logic [15:0] DEC_100   = 16'h0064;
  localparam logic [15:0] DEC_10    = 16'h000a;
  localparam logic [6:0]  UD_STEP_PCT = 7'h0a;

endpackage

/* File: design/commutation_feedback_config.sv */
// Commutation and position feedback configuration: Hall angle table,
// phase order, encoder direction, index offset and window, limit options.
// Assumes motor_running, power_up_load and the learning port come from
// logic on core_clk; Hall and encoder inputs are asynchronous pins.
// Notes on behaviour
// - Each Hall code 1-6 gives its angle.
// - Codes 1,2,3 reset to 425,85,255.
// - Codes 4,5,6 reset to 765,595,935.
// - Self-learning writes Hall angles and direction.
// - Direction 0 normal, 1 swaps channels.
// - Index offset output applies immediately.
// - Protected writes need the unlock key.
// - Top limit digit 1 disables voltage limit.
// - Fourth digit 0-9 gives 10-100 percent.
// - Digits two, three, five give gains, compensation.
// - Index window eight bits, reset 22.
// - Pitch, resolution, limits latch at power-up.
`timescale 1ns/10ps
module commutation_feedback_config (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        motor_running,
  input  wire logic        power_up_load,
  input  wire logic        learn_angle_wr,
  input  wire logic [2:0]  learn_code,
  input  wire logic [9:0]  learn_angle,
  input  wire logic        learn_dir_wr,
  input  wire logic        learn_dir,
  input  wire logic [2:0]  hall_pins,
  input  wire logic        enc_a_pin,
  input  wire logic        enc_b_pin,
  output logic      [9:0]  hall_angle,
  output logic             hall_valid,
  output logic             enc_a,
  output logic             enc_b,
  output logic             phase_reversed,
  output logic      [14:0] index_offset,
  output logic      [7:0]  index_window,
  output logic      [15:0] active_pole_pitch,
  output logic      [15:0] active_scale_res,
  output logic             volt_limit_disable,
  output logic      [3:0]  fw_kp,
  output logic      [3:0]  fw_ki,
  output logic      [6:0]  ud_limit_pct,
  output logic      [3:0]  phase_comp_mult
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.
  logic [4:0] sync_q;
  logic [2:0] hall_code;
  logic       enc_a_s;
  logic       enc_b_s;
  pin_sync #(.WIDTH(commutation_cfg_pkg::SYNC_W)) u_pin_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .pin_in   ({enc_b_pin, enc_a_pin, hall_pins}),
    .pin_out  (sync_q)
  );
  assign hall_code = sync_q[2:0];
  assign enc_a_s   = sync_q[3];
  assign enc_b_s   = sync_q[4];

  //////////////////////////////////////////////////////////////////////////////
  // Write qualification.
  logic        unlocked;
  logic        write_rejected;
  logic [15:0] pole_pitch;
  logic [15:0] scale_res;
  logic [15:0] limit_opt;
  logic        quad_dir;
  logic [9:0]  hall_tab [0:5];
  logic stop_ok;
  logic prot_ok;
  logic hit_pitch;
  logic hit_res;
  logic hit_limit;
  logic hit_phase;
  logic hit_offset;
  logic hit_dir;
  logic hit_hall;
  logic hit_window;
  logic hit_stop_reg;
  logic hit_prot_reg;
  logic reject_now;
  logic clear_reject;
  assign stop_ok      = reg_wr && !motor_running;
  assign prot_ok      = stop_ok && unlocked;
  assign hit_pitch    = reg_addr == commutation_cfg_pkg::ADDR_POLE_PITCH;
  assign hit_res      = reg_addr == commutation_cfg_pkg::ADDR_SCALE_RES;
  assign hit_limit    = reg_addr == commutation_cfg_pkg::ADDR_LIMIT_OPT;
  assign hit_phase    = reg_addr == commutation_cfg_pkg::ADDR_PHASE_ORDER;
  assign hit_offset   = reg_addr == commutation_cfg_pkg::ADDR_INDEX_OFFSET;
  assign hit_dir      = reg_addr == commutation_cfg_pkg::ADDR_QUAD_DIR;
  assign hit_window   = reg_addr == commutation_cfg_pkg::ADDR_INDEX_WINDOW;
  assign hit_hall     = reg_addr >= commutation_cfg_pkg::ADDR_HALL_BASE &&
                        reg_addr < commutation_cfg_pkg::ADDR_INDEX_WINDOW;
  assign hit_stop_reg = hit_pitch || hit_res || hit_limit || hit_phase;
  assign hit_prot_reg = hit_offset || hit_dir || hit_hall || hit_window;
  assign reject_now   = reg_wr && ((hit_stop_reg && !stop_ok) ||
                                   (hit_prot_reg && !prot_ok));
  assign clear_reject = reg_wr && reg_addr == commutation_cfg_pkg::ADDR_STATUS &&
                        reg_wdata[commutation_cfg_pkg::STAT_REJECTED];

  // Any write to the unlock register with another value locks again, so a
  // stray write cannot leave the protected settings open.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      unlocked       <= 1'b0;
      write_rejected <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == commutation_cfg_pkg::ADDR_UNLOCK)
        unlocked <= reg_wdata == commutation_cfg_pkg::UNLOCK_KEY;
      // A rejection in the clearing cycle stays recorded.
      write_rejected <= reject_now || (write_rejected && !clear_reject);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Stored settings.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pole_pitch     <= commutation_cfg_pkg::RST_POLE_PITCH;
      scale_res      <= commutation_cfg_pkg::RST_SCALE_RES;
      limit_opt      <= commutation_cfg_pkg::RST_LIMIT_OPT;
      phase_reversed <= commutation_cfg_pkg::RST_PHASE_ORDER;
      index_offset   <= commutation_cfg_pkg::RST_INDEX_OFFSET;
      quad_dir       <= commutation_cfg_pkg::RST_QUAD_DIR;
      index_window   <= commutation_cfg_pkg::RST_INDEX_WINDOW;
    end
    else
    begin
      if (stop_ok && hit_pitch)
        pole_pitch <= reg_wdata;
      if (stop_ok && hit_res)
        scale_res <= reg_wdata;
      if (stop_ok && hit_limit)
        limit_opt <= reg_wdata;
      if (stop_ok && hit_phase)
        phase_reversed <= reg_wdata[0];
      if (prot_ok && hit_offset)
        index_offset <= reg_wdata[14:0];
      if (learn_dir_wr)
        quad_dir <= learn_dir;
      else if (prot_ok && hit_dir)
        quad_dir <= reg_wdata[0];
      if (prot_ok && hit_window)
        index_window <= reg_wdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Hall angle table; learning wins over a software write in the same cycle.
  genvar g;
  generate
    for (g = 0; g < commutation_cfg_pkg::HALL_N; g++)
    begin : g_hall
      logic learn_we;
      logic sw_we;
      assign learn_we = learn_angle_wr && learn_code == 3'(g + 1);
      assign sw_we    = prot_ok && reg_addr == 5'(commutation_cfg_pkg::ADDR_HALL_BASE + g);
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
          hall_tab[g] <= commutation_cfg_pkg::RST_HALL_ANGLE[g];
        else if (learn_we)
          hall_tab[g] <= learn_angle;
        else if (sw_we)
          hall_tab[g] <= reg_wdata[9:0];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Hall lookup and encoder channel order.
  logic       hall_ok;
  logic [2:0] hall_idx;
  assign hall_ok  = hall_code >= 3'h1 && hall_code <= 3'h6;
  assign hall_idx = hall_ok ? 3'(hall_code - 3'h1) : 3'h0;

  // An invalid code keeps the last angle so commutation does not jump.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hall_angle <= 10'h000;
      hall_valid <= 1'b0;
      enc_a      <= 1'b0;
      enc_b      <= 1'b0;
    end
    else
    begin
      hall_valid <= hall_ok;
      if (hall_ok)
        hall_angle <= hall_tab[hall_idx];
      enc_a <= quad_dir ? enc_b_s : enc_a_s;
      enc_b <= quad_dir ? enc_a_s : enc_b_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power-up latching of pitch, resolution and limit options.
  logic        load_pending;
  logic        latch_now;
  logic [15:0] active_limit;
  assign latch_now = load_pending || power_up_load;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      load_pending      <= 1'b1;
      active_pole_pitch <= commutation_cfg_pkg::RST_POLE_PITCH;
      active_scale_res  <= commutation_cfg_pkg::RST_SCALE_RES;
      active_limit      <= commutation_cfg_pkg::RST_LIMIT_OPT;
    end
    else
    begin
      load_pending <= 1'b0;
      if (latch_now)
      begin
        active_pole_pitch <= pole_pitch;
        active_scale_res  <= scale_res;
        active_limit      <= limit_opt;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decimal digits of the active limit options, most significant first.
  logic [15:0] dig_a;
  logic [15:0] rem_a;
  logic [15:0] dig_b;
  logic [15:0] rem_b;
  logic [15:0] dig_c;
  logic [15:0] rem_c;
  logic [15:0] dig_d;
  logic [15:0] dig_e;
  logic [6:0]  ud_pct;
  assign dig_a  = active_limit / commutation_cfg_pkg::DEC_10000;
  assign rem_a  = active_limit % commutation_cfg_pkg::DEC_10000;
  assign dig_b  = rem_a / commutation_cfg_pkg::DEC_1000;
  assign rem_b  = rem_a % commutation_cfg_pkg::DEC_1000;
  assign dig_c  = rem_b / commutation_cfg_pkg::DEC_100;
  assign rem_c  = rem_b % commutation_cfg_pkg::DEC_100;
  assign dig_d  = rem_c / commutation_cfg_pkg::DEC_10;
  assign dig_e  = rem_c % commutation_cfg_pkg::DEC_10;
  assign ud_pct = 7'((dig_d[3:0] + 4'h1) * commutation_cfg_pkg::UD_STEP_PCT);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      volt_limit_disable <= 1'b0;
      fw_kp              <= 4'h0;
      fw_ki              <= 4'h0;
      ud_limit_pct       <= commutation_cfg_pkg::UD_STEP_PCT;
      phase_comp_mult    <= 4'h0;
    end
    else
    begin
      volt_limit_disable <= dig_a == 16'h0001;
      fw_kp              <= dig_b[3:0];
      fw_ki              <= dig_c[3:0];
      ud_limit_pct       <= ud_pct;
      phase_comp_mult    <= dig_e[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port: data stand only in the cycle after the strobe.
  logic [15:0] next_rdata;
  logic [15:0] status_word;

  assign status_word = {13'h0000, write_rejected, motor_running, unlocked};

  always_comb
  begin
    next_rdata = 16'h0000;
    if (hit_pitch)
      next_rdata = pole_pitch;
    else if (hit_res)
      next_rdata = scale_res;
    else if (hit_limit)
      next_rdata = limit_opt;
    else if (hit_phase)
      next_rdata = {15'h0000, phase_reversed};
    else if (hit_offset)
      next_rdata = {1'b0, index_offset};
    else if (hit_dir)
      next_rdata = {15'h0000, quad_dir};
    else if (hit_hall)
      next_rdata = {6'h00, hall_tab[3'(reg_addr - commutation_cfg_pkg::ADDR_HALL_BASE)]};
    else if (hit_window)
      next_rdata = {8'h00, index_window};
    else if (reg_addr == commutation_cfg_pkg::ADDR_STATUS)
      next_rdata = status_word;
    else if (reg_addr == commutation_cfg_pkg::ADDR_ACTIVE_PITCH)
      next_rdata = active_pole_pitch;
    else if (reg_addr == commutation_cfg_pkg::ADDR_ACTIVE_RES)
      next_rdata = active_scale_res;
    else if (reg_addr == commutation_cfg_pkg::ADDR_ACTIVE_LIMIT)
      next_rdata = active_limit;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_rd ? next_rdata : 16'h0000;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_hall_low_reset: assert property (@(posedge core_clk)
    $rose(resetn) |-> hall_tab[0] == 10'h1a9 && hall_tab[1] == 10'h055 &&
                      hall_tab[2] == 10'h0ff)
    else $error("Hall entries 1 to 3 wrong after reset.");
  a_hall_high_reset: assert property (@(posedge core_clk)
    $rose(resetn) |-> hall_tab[3] == 10'h2fd && hall_tab[4] == 10'h253 &&
                      hall_tab[5] == 10'h3a7)
    else $error("Hall entries 4 to 6 wrong after reset.");
  a_hall_lookup: assert property (@(posedge core_clk) disable iff (!resetn)
    hall_code == 3'h3 && !learn_angle_wr && !reg_wr |=> hall_valid && hall_angle == hall_tab[2])
    else $error("Hall code 3 did not select its angle.");
  a_learn_angle: assert property (@(posedge core_clk) disable iff (!resetn)
    learn_angle_wr && learn_code == 3'h2 |=> hall_tab[1] == $past(learn_angle))
    else $error("Learned angle not stored.");
  a_dir_swap: assert property (@(posedge core_clk) disable iff (!resetn)
    quad_dir && $past(quad_dir) |-> ##1 enc_a == $past(enc_b_s) && enc_b == $past(enc_a_s))
    else $error("Encoder channels not swapped.");
  a_locked_offset: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_wr && hit_offset && !unlocked |=> $stable(index_offset))
    else $error("Index offset written while locked.");
  a_offset_apply: assert property (@(posedge core_clk) disable iff (!resetn)
    prot_ok && hit_offset |=> index_offset == $past(reg_wdata[14:0]))
    else $error("Index offset not applied at once.");
  a_running_phase: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_wr && hit_phase && motor_running |=> $stable(phase_reversed) && write_rejected)
    else $error("Phase order changed while running.");
  a_latch_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    !latch_now |=> $stable(active_limit) && $stable(active_pole_pitch))
    else $error("Active setting changed outside power-up.");
  a_volt_disable: assert property (@(posedge core_clk) disable iff (!resetn)
    active_limit >= 16'h2710 && active_limit < 16'h4e20 && $stable(active_limit)
    |=> volt_limit_disable)
    else $error("Voltage limit not disabled by top digit.");
  a_ud_range: assert property (@(posedge core_clk) disable iff (!resetn)
    ud_limit_pct >= 7'h0a && ud_limit_pct <= 7'h64 && ud_limit_pct % 7'h0a == 7'h00)
    else $error("Voltage limit percentage out of range.");

endmodule // commutation_feedback_config

/* File: design/pin_sync.sv */
// Two flip-flop synchroniser for a group of unrelated pin levels.
// Assumes each bit is an independent level; no bus coherency is given.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] stage1;

  // Only the second stage reads the first.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1  <= '0;
      pin_out <= '0;
    end
    else
    begin
      stage1  <= pin_in;
      pin_out <= stage1;
    end
  end

endmodule // pin_sync

/* File: sim/commutation_feedback_config_tb_top.sv */
// Self-checking bench for the commutation and feedback configuration block.
// Assumes the register map and unlock key of the block's package.
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("Error at %0t ns: value %h, expected %h", $time, got, exp); \
    end \
  end
module commutation_feedback_config_tb_top;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        motor_running = 1'b0;
  logic        power_up_load = 1'b0;
  logic        learn_angle_wr = 1'b0;
  logic [2:0]  learn_code = 3'h0;
  logic [9:0]  learn_angle = 10'h000;
  logic        learn_dir_wr = 1'b0;
  logic        learn_dir = 1'b0;
  logic [2:0]  hall_code = 3'h0;
  logic [1:0]  enc_phase = 2'h0;
  logic [2:0]  hall_pins;
  logic        enc_a_pin, enc_b_pin, hall_valid, enc_a, enc_b, phase_reversed;
  logic        volt_limit_disable;
  logic [9:0]  hall_angle;
  logic [14:0] index_offset;
  logic [7:0]  index_window;
  logic [15:0] active_pole_pitch, active_scale_res, rdv, v;
  logic [3:0]  fw_kp, fw_ki, phase_comp_mult;
  logic [6:0]  ud_limit_pct;
  logic [9:0]  exp_angle [1:6];
  int          failures = 0;
  int          compares = 0;
  int          dg [0:4];

  initial forever #2.5 core_clk = ~core_clk;

  motor_sensor_model i_motor_sensor_model (.hall_code(hall_code), .enc_phase(enc_phase),
    .hall_pins(hall_pins), .enc_a_pin(enc_a_pin), .enc_b_pin(enc_b_pin));

  commutation_feedback_config i_commutation_feedback_config (.core_clk(core_clk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_running(motor_running),
    .power_up_load(power_up_load), .learn_angle_wr(learn_angle_wr), .learn_code(learn_code),
    .learn_angle(learn_angle), .learn_dir_wr(learn_dir_wr), .learn_dir(learn_dir),
    .hall_pins(hall_pins), .enc_a_pin(enc_a_pin), .enc_b_pin(enc_b_pin),
    .hall_angle(hall_angle), .hall_valid(hall_valid), .enc_a(enc_a), .enc_b(enc_b),
    .phase_reversed(phase_reversed), .index_offset(index_offset),
    .index_window(index_window), .active_pole_pitch(active_pole_pitch),
    .active_scale_res(active_scale_res), .volt_limit_disable(volt_limit_disable),
    .fw_kp(fw_kp), .fw_ki(fw_ki), .ud_limit_pct(ud_limit_pct),
    .phase_comp_mult(phase_comp_mult));

  //////////////////////////////////////////////////////////////////////////////
  // Bus tasks start one edge late so a strobe is never lowered and raised in one step.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic pulse_learn(input logic [2:0] c, input logic [9:0] ang, input logic dir);
    @(posedge core_clk);
    learn_angle_wr <= (c != 3'h0);
    learn_code <= c;
    learn_angle <= ang;
    learn_dir_wr <= (c == 3'h0);
    learn_dir <= dir;
    @(posedge core_clk);
    learn_angle_wr <= 1'b0;
    learn_dir_wr <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [15:0] limit_word();
    return 16'(dg[0] * 10000 + dg[1] * 1000 + dg[2] * 100 + dg[3] * 10 + dg[4]);
  endfunction

  task automatic stop_test;
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    failures++;
    stop_test;
  end

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h9d519088));
    exp_angle = '{10'h1a9, 10'h055, 10'h0ff, 10'h2fd, 10'h253, 10'h3a7};
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    settle(2);
    `CHK(phase_reversed, 1'b1)
    `CHK(index_window, 8'h16)
    `CHK(ud_limit_pct, 7'h0a)
    for (int i = 1; i <= 6; i++)
    begin
      rd(5'(commutation_cfg_pkg::ADDR_HALL_BASE + i - 1), rdv);
      `CHK(rdv, {6'h00, exp_angle[i]})
    end
    rd(commutation_cfg_pkg::ADDR_QUAD_DIR, rdv);
    `CHK(rdv, 16'h0000)
    // Protected write while locked must be refused and flagged.
    wr(commutation_cfg_pkg::ADDR_INDEX_OFFSET, 16'h1234);
    `CHK(index_offset, 15'h0000)
    rd(commutation_cfg_pkg::ADDR_STATUS, rdv);
    `CHK(rdv[commutation_cfg_pkg::STAT_REJECTED], 1'b1)
    wr(commutation_cfg_pkg::ADDR_STATUS, 16'h0004);
    rd(commutation_cfg_pkg::ADDR_STATUS, rdv);
    `CHK(rdv[2:0], 3'h0)
    rd(5'h1f, rdv);
    `CHK(rdv, 16'h0000)
    wr(commutation_cfg_pkg::ADDR_UNLOCK, commutation_cfg_pkg::UNLOCK_KEY);
    v = 16'($urandom);
    wr(commutation_cfg_pkg::ADDR_INDEX_OFFSET, v);
    `CHK(index_offset, v[14:0])
    v = 16'($urandom);
    wr(commutation_cfg_pkg::ADDR_INDEX_WINDOW, v);
    `CHK(index_window, v[7:0])
    // Full 16-bit angles are written; only the value modulo 1024 may survive.
    for (int i = 1; i <= 6; i++)
    begin
      v = 16'($urandom) | 16'h0400;
      wr(5'(commutation_cfg_pkg::ADDR_HALL_BASE + i - 1), v);
      exp_angle[i] = v[9:0];
    end
    for (int i = 1; i <= 7; i++)
    begin
      hall_code <= 3'(i);
      settle(5);
      `CHK(hall_valid, (i != 7))
      `CHK(hall_angle, exp_angle[(i == 7) ? 6 : i])
    end
    for (int d = 0; d < 2; d++)
    begin
      wr(commutation_cfg_pkg::ADDR_QUAD_DIR, 16'(d));
      for (int p = 0; p < 4; p++)
      begin
        enc_phase <= 2'(p + 1);
        settle(5);
        `CHK({enc_a, enc_b}, (d == 1) ? {enc_b_pin, enc_a_pin} : {enc_a_pin, enc_b_pin})
      end
    end
    wr(commutation_cfg_pkg::ADDR_PHASE_ORDER, 16'h0000);
    `CHK(phase_reversed, 1'b0)
    // While the motor runs, stop-to-set writes are refused.
    motor_running <= 1'b1;
    wr(commutation_cfg_pkg::ADDR_PHASE_ORDER, 16'h0001);
    `CHK(phase_reversed, 1'b0)
    wr(commutation_cfg_pkg::ADDR_HALL_BASE, 16'h0000);
    rd(commutation_cfg_pkg::ADDR_HALL_BASE, rdv);
    `CHK(rdv[9:0], exp_angle[1])
    // Self-learning goes through even while locked and running.
    wr(commutation_cfg_pkg::ADDR_UNLOCK, 16'h0000);
    v = 16'($urandom);
    pulse_learn(3'h2, v[9:0], 1'b0);
    pulse_learn(3'h0, 10'h000, 1'b0);
    rd(5'(commutation_cfg_pkg::ADDR_HALL_BASE + 1), rdv);
    `CHK(rdv[9:0], v[9:0])
    rd(commutation_cfg_pkg::ADDR_QUAD_DIR, rdv);
    `CHK(rdv[0], 1'b0)
    motor_running <= 1'b0;
    // Limit options and linear settings wait for the next power-up.
    for (int k = 0; k < 6; k++)
    begin
      foreach (dg[j]) dg[j] = (j == 0) ? $urandom_range(1) : $urandom_range(9);
      if (k == 0) dg[3] = 0;
      if (k == 1) dg[3] = 9;
      dg[0] = (k < 2) ? 1 - k : dg[0];
      v = 16'($urandom);
      wr(commutation_cfg_pkg::ADDR_POLE_PITCH, v);
      wr(commutation_cfg_pkg::ADDR_SCALE_RES, ~v);
      wr(commutation_cfg_pkg::ADDR_LIMIT_OPT, limit_word());
      `CHK(active_pole_pitch === v, 1'b0)
      @(posedge core_clk);
      power_up_load <= 1'b1;
      @(posedge core_clk);
      power_up_load <= 1'b0;
      settle(2);
      `CHK(active_pole_pitch, v)
      `CHK(active_scale_res, ~v)
      `CHK(volt_limit_disable, (dg[0] == 1))
      `CHK(ud_limit_pct, 7'((dg[3] + 1) * 10))
      `CHK({fw_kp, fw_ki, phase_comp_mult}, {4'(dg[1]), 4'(dg[2]), 4'(dg[4])})
      rd(commutation_cfg_pkg::ADDR_ACTIVE_LIMIT, rdv);
      `CHK(rdv, limit_word())
    end
    stop_test;
  end
endmodule // commutation_feedback_config_tb_top

/* File: sim/motor_sensor_model.sv */
// Far-side model of the motor Hall sensors and the incremental encoder.
// Assumes the bench commands a Hall code and an encoder phase (0..3 in Gray order).
`timescale 1ns/10ps
module motor_sensor_model (
  input  wire logic [2:0] hall_code,
  input  wire logic [1:0] enc_phase,
  output logic      [2:0] hall_pins,
  output logic            enc_a_pin,
  output logic            enc_b_pin
);
  // Sensor edges land off the clock edge, since real sensors know nothing of the core clock.
  assign #1.3 hall_pins = hall_code;
  assign #1.3 enc_a_pin = enc_phase[1];
  assign #1.3 enc_b_pin = enc_phase[1] ^ enc_phase[0];
endmodule // motor_sensor_model
